// file: shp_asserts.sv
// Checker for the host bus port
`timescale 1ns/100ps
module shp_chk
    import shp_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // Host pins
    input wire logic       ce_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       irq_ack_n,
    input wire logic       chain_in,
    input wire logic       data_oe,
    input wire logic [7:0] data_out,
    input wire logic       chain_out,
    input wire logic       int_req_n,
    // Channel port
    input wire shp_acc_t   acc,
    input wire logic [7:0] acc_rdata
);
    // ==========
    // Common timing
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Any channel access pulse
    wire any_acc = acc.rd | acc.wr;
    // Both strobes low: pin reset
    sequence s_pin_rst;
        (!rd_n && !wr_n) [*3];
    endsequence
    // Acknowledge low long enough to cross the synchroniser
    sequence s_ack_on;
        !irq_ack_n [*5];
    endsequence
    // Read strobe in an acknowledge with a request open
    sequence s_ack_rd;
        $fell(rd_n) && !irq_ack_n && chain_in && !int_req_n;
    endsequence
    // ==========
    // Properties
    a_drive_win: assert property ((!rd_n && !ce_n |-> data_oe) and (rd_n |-> !data_oe))
        else $error("drive enable wrong");
    a_wr_single: assert property (acc.wr |=> !acc.wr)
        else $error("write pulse too long");
    a_rd_single: assert property (acc.rd |=> !acc.rd)
        else $error("read pulse too long");
    a_no_overlap: assert property (!(acc.rd && acc.wr))
        else $error("read and write together");
    a_recov_gap: assert property (any_acc |=> !any_acc [*3])
        else $error("access inside recovery");
    a_ack_ignore: assert property (s_ack_on |-> !acc.wr)
        else $error("write taken in acknowledge");
    a_read_data: assert property (acc.rd |=> ##1 (data_out == $past(acc_rdata)))
        else $error("read data not passed on");
    a_reset_quiet: assert property (s_pin_rst |=> !any_acc [*6])
        else $error("access during reset");
    a_irq_release: assert property (s_ack_rd |-> ##[1:8] int_req_n)
        else $error("request not released");
    a_chain_block: assert property (!irq_ack_n && $rose(int_req_n) |-> !chain_out)
        else $error("chain open while served");
endmodule
bind shp_host_port shp_chk i_shp_chk (
    .sys_clk(sys_clk), .rstn(rstn), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
    .irq_ack_n(irq_ack_n), .chain_in(chain_in), .data_oe(data_oe),
    .data_out(data_out), .chain_out(chain_out), .int_req_n(int_req_n),
    .acc(acc), .acc_rdata(acc_rdata)
);

// file: shp_host_model.sv
// Host processor model on the port's bus pins
`timescale 1ns/100ps
module shp_host_model (
    // Clock
    input wire logic       sys_clk,
    // Bus pins
    output logic           ce_n,
    output logic           rd_n,
    output logic           wr_n,
    output logic           irq_ack_n,
    output logic           dc_sel,
    output logic           ab_sel,
    output logic [7:0]     data_in,
    output logic           chain_in,
    // Read data back
    input wire logic [7:0] data_out
);
    // ==========
    // Idle bus; the chain above always enables us
    initial begin
        {ce_n, rd_n, wr_n, irq_ack_n} = 4'hF;
        {dc_sel, ab_sel, chain_in} = 3'h1;
        data_in = 8'hA5;
    end
    // One access: strobe held hold cycles, then gap idle cycles
    task automatic xfer(input logic wr, dc, ab, input logic [7:0] d,
                        input int hold, gap, output logic [7:0] q);
        @(posedge sys_clk);
        dc_sel <= dc;
        ab_sel <= ab;
        data_in <= d;
        ce_n <= 1'h0;
        wr_n <= !wr;
        rd_n <= wr;
        repeat (hold) @(posedge sys_clk);
        {ce_n, rd_n, wr_n} <= 3'h7;
        // Released bus shows no stale byte
        data_in <= ~d;
        repeat (gap) @(posedge sys_clk);
        #1 q = data_out;
    endtask
    // Acknowledge level, then time for the chain to settle
    task automatic set_ack(input logic v);
        @(posedge sys_clk);
        irq_ack_n <= v;
        repeat (3) @(posedge sys_clk);
    endtask
    // Exactly one read strobe per acknowledge
    task automatic ack_rd(output logic [7:0] q);
        @(posedge sys_clk);
        rd_n <= 1'h0;
        repeat (4) @(posedge sys_clk);
        rd_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        #1 q = data_out;
    endtask
    // Both strobes low together
    task automatic hw_reset();
        @(posedge sys_clk);
        {rd_n, wr_n} <= 2'h0;
        repeat (4) @(posedge sys_clk);
        {rd_n, wr_n} <= 2'h3;
    endtask
endmodule

// file: shp_host_port.sv
// Host bus port of the dual-channel serial controller
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps

module shp_host_port
    import shp_pkg::*;
(
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    // Host bus pins
    input  wire logic            ce_n,
    input  wire logic            rd_n,
    input  wire logic            wr_n,
    input  wire logic            irq_ack_n,
    input  wire logic            dc_sel,
    input  wire logic            ab_sel,
    input  wire logic [7:0]      data_in,
    output logic      [7:0]      data_out,
    output logic                 data_oe,
    // Daisy chain and interrupt request
    input  wire logic            chain_in,
    output logic                 chain_out,
    output logic                 int_req_n,
    // Channel register port
    output shp_acc_t             acc,
    input  wire logic [7:0]      acc_rdata,
    // Channel interrupt sources
    input  wire logic [NSRC-1:0] irq_src,
    // Block event interrupt
    output logic                 evt_irq
);

    // ==========================================================
    // Declarations
    shp_pins_t       raw_pins;     // Pins bundled for the synchroniser
    shp_pins_t       pins_s;       // Synchronised pins
    logic            rd_act_q;     // Enable with read strobe, delayed
    logic            wr_act_q;     // Enable with write strobe, delayed
    logic            ackrd_q;      // Read strobe, delayed, for the acknowledge edge
    logic            rd_act;       // Read coincidence now
    logic            wr_act;       // Write coincidence now
    logic            rd_go;        // Read coincidence began
    logic            wr_go;        // Write coincidence began
    logic            ack_go;       // Read strobe fell in acknowledge
    logic            hw_rst;       // Both strobes low
    logic            in_reset;     // Reset held or stretched
    logic [2:0]      rst_cnt_q;    // Reset stretch counter
    logic [2:0]      rec_cnt_q;    // Recovery counter
    logic            take;         // Access accepted this cycle
    logic            refuse;       // Access ignored this cycle
    logic [3:0]      ptr_q;        // Register pointer
    logic [3:0]      idx;          // Register reached by this access
    logic            internal;     // Access hits this block's registers
    logic [7:0]      vector_q;     // Interrupt vector
    logic [EV_W-1:0] stat_q;       // Sticky event status
    logic [EV_W-1:0] mask_q;       // Event mask
    logic [EV_W-1:0] ev_set;       // Events this cycle
    logic [EV_W-1:0] w1c;          // Status bits written with one
    logic            div_q;        // Half-rate toggle
    logic            upd_en;       // Pending update enable
    logic            svc_clr;      // Clear highest in-service
    logic            ack_take;     // Acknowledge aimed at this chain
    logic            hit;          // A vector is due
    logic [NSRC-1:0] pending;      // Pending bits
    // In-service bits stay inside the interrupt unit
    logic [7:0]      int_rdata;    // Internal read value
    logic [7:0]      int_rd_q;     // Internal read value, held
    logic            rd_p1_q;      // Read pipeline stage one
    logic            rd_p2_q;      // Read pipeline stage two
    logic            rd_ext_q;     // Read goes to channel registers
    logic            ext_p2_q;     // Same, aligned with stage two
    logic [7:0]      data_out_q;   // Read data for the host
    shp_acc_t        acc_q;        // Registered channel access

    // ==========================================================
    // Pin synchroniser
    assign raw_pins = '{ce_n: ce_n, rd_n: rd_n, wr_n: wr_n,
                        irq_ack_n: irq_ack_n, dc_sel: dc_sel,
                        ab_sel: ab_sel, chain_in: chain_in,
                        data: data_in};

    // Every pin crosses two flops before any decision but the drive enable
    shp_sync #(
        .W ($bits(shp_pins_t))
    ) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in (raw_pins),
        .sync_out (pins_s)
    );

    // ==========================================================
    // Strobe decode and edge detection
    assign rd_act = ~pins_s.ce_n & ~pins_s.rd_n;
    assign wr_act = ~pins_s.ce_n & ~pins_s.wr_n;
    assign hw_rst = ~pins_s.rd_n & ~pins_s.wr_n;

    // Delayed copies for edge detection
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            ackrd_q  <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            ackrd_q  <= ~pins_s.rd_n;
        end
    end

    // Acknowledge low masks enable, selects and write entirely
    assign rd_go  = rd_act & ~rd_act_q & pins_s.irq_ack_n;
    assign wr_go  = wr_act & ~wr_act_q & pins_s.irq_ack_n;
    assign ack_go = ~pins_s.rd_n & ~ackrd_q & ~pins_s.irq_ack_n
                  & ~in_reset;

    // ==========================================================
    // Hardware reset stretch
    // Counter reloads while both strobes are low, then runs out
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_q <= 3'h0;
        end else if (hw_rst) begin
            rst_cnt_q <= RST_STRETCH_CYC;
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end
    end

    assign in_reset = hw_rst | (rst_cnt_q != 3'h0);

    // ==========================================================
    // Access acceptance and recovery
    // A start inside recovery or reset is dropped, not queued
    assign take   = (rd_go | wr_go) & ~in_reset
                  & (rec_cnt_q == 3'h0);
    assign refuse = (rd_go | wr_go) & ~take;

    // Recovery counts from the accepted strobe edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rec_cnt_q <= 3'h0;
        end else if (take) begin
            rec_cnt_q <= RECOVERY_CYC;
        end else if (rec_cnt_q != 3'h0) begin
            rec_cnt_q <= rec_cnt_q - 3'h1;
        end
    end

    // Data select bypasses the pointer entirely
    assign idx = pins_s.dc_sel ? IDX_DATA : ptr_q;

    // Only a few indices belong to this block
    assign internal = (idx == IDX_CMD) || (idx == IDX_VECTOR)
                   || (idx == IDX_PENDING) || (idx == IDX_EVT_STAT)
                   || (idx == IDX_EVT_MASK);

    // ==========================================================
    // Register pointer
    // Loading from the command register, else cleared by control access
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= IDX_ZERO;
        end else if (in_reset) begin
            ptr_q <= IDX_ZERO;
        end else if (take && !pins_s.dc_sel) begin
            if (wr_go && idx == IDX_CMD) begin
                ptr_q <= {pins_s.data[CMD_MSB:CMD_LSB] == CMD_POINT_HIGH,
                          pins_s.data[PTR_MSB:PTR_LSB]};
            end else begin
                ptr_q <= IDX_ZERO;
            end
        end
    end

    // Command to release the highest in-service level
    assign svc_clr = take && wr_go && !pins_s.dc_sel && idx == IDX_CMD
                  && pins_s.data[CMD_MSB:CMD_LSB] == CMD_SVC_CLR;

    // ==========================================================
    // Vector, event status and mask registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vector_q <= VECTOR_RST;
        end else if (take && wr_go && idx == IDX_VECTOR) begin
            vector_q <= pins_s.data;
        end
    end

    // Event mask
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= '0;
        end else if (take && wr_go && idx == IDX_EVT_MASK) begin
            mask_q <= pins_s.data[EV_W-1:0];
        end
    end

    // Events that hardware reports
    always_comb begin
        ev_set             = '0;
        ev_set[EV_ACCESS]  = take;
        ev_set[EV_ACK]     = ack_take & hit;
        ev_set[EV_RESET]   = (rst_cnt_q == 3'h1) & ~hw_rst;
        ev_set[EV_REFUSED] = refuse;
    end

    assign w1c = (take && wr_go && idx == IDX_EVT_STAT)
               ? pins_s.data[EV_W-1:0] : '0;

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~w1c) | ev_set;
        end
    end

    assign evt_irq = |(stat_q & mask_q);

    // ==========================================================
    // Interrupt section
    // Half-rate update, held while the pointer rests on 2 or 3
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 1'b0;
        end else begin
            div_q <= ~div_q;
        end
    end

    assign upd_en = div_q & (ptr_q != IDX_VECTOR)
                  & (ptr_q != IDX_PENDING);

    // The chain input gates whether this device claims the cycle
    assign ack_take = ack_go & pins_s.chain_in;

    shp_irq_unit u_irq (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .soft_rst    (in_reset),
        .src         (irq_src),
        .upd_en      (upd_en),
        .ack_active  (~pins_s.irq_ack_n),
        .ack_take    (ack_take),
        .svc_clr     (svc_clr),
        .chain_in    (pins_s.chain_in),
        .pending_q   (pending),
        .svc_q       (),
        .hit         (hit),
        .chain_out_q (chain_out),
        .int_n_q     (int_req_n)
    );

    // ==========================================================
    // Read path
    always_comb begin
        int_rdata = BYTE_ZERO;
        case (idx)
            IDX_VECTOR:   int_rdata = vector_q;
            IDX_PENDING:  int_rdata = {{(8 - NSRC){1'b0}}, pending};
            IDX_EVT_STAT: int_rdata = {{(8 - EV_W){1'b0}}, stat_q};
            IDX_EVT_MASK: int_rdata = {{(8 - EV_W){1'b0}}, mask_q};
            default:      int_rdata = BYTE_ZERO;
        endcase
    end

    // Channel data returns one cycle after the access pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_p1_q  <= 1'b0;
            rd_p2_q  <= 1'b0;
            rd_ext_q <= 1'b0;
            ext_p2_q <= 1'b0;
            int_rd_q <= BYTE_ZERO;
        end else begin
            rd_p1_q  <= take & rd_go;
            rd_p2_q  <= rd_p1_q;
            ext_p2_q <= rd_ext_q;
            if (take && rd_go) begin
                rd_ext_q <= ~internal;
                int_rd_q <= int_rdata;
            end
        end
    end

    // Host data register: vector in acknowledge, else read data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out_q <= BYTE_ZERO;
        end else if (ack_take && hit) begin
            data_out_q <= vector_q;
        end else if (rd_p2_q) begin
            data_out_q <= ext_p2_q ? acc_rdata : int_rd_q;
        end
    end

    assign data_out = data_out_q;

    // Raw pins: a synchronised enable would keep driving past release
    assign data_oe = ~rd_n & (~ce_n | ~irq_ack_n);

    // ==========================================================
    // Channel register access, one-cycle pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= '0;
        end else begin
            acc_q.rd     <= take & rd_go & ~internal;
            acc_q.wr     <= take & wr_go & ~internal;
            if (take) begin
                acc_q.ab_sel <= pins_s.ab_sel;
                acc_q.idx    <= idx;
                acc_q.wdata  <= pins_s.data;
            end
        end
    end

    assign acc = acc_q;

endmodule

// file: shp_host_port_test.sv
// Bench for the host bus port
`timescale 1ns/100ps
module shp_host_port_test import shp_pkg::*;;
    // ==========
    // Nets and bench state
    logic            sys_clk, rstn, data_oe, chain_out, int_req_n, evt_irq, ab;
    wire             ce_n, rd_n, wr_n, irq_ack_n, dc_sel, ab_sel, chain_in;
    wire  [7:0]      data_in;
    logic [7:0]      data_out, acc_rdata, q, v;
    logic [NSRC-1:0] irq_src;
    logic [31:0]     rs;
    shp_acc_t        acc, last_acc;
    int              err_total, n_tests, n_wr, n0;
    logic [7:0]      pv [5] = '{8'h01, 8'h04, 8'h05, 8'h0C, 8'h0F};
    shp_host_port i_shp_host_port (.sys_clk(sys_clk), .rstn(rstn), .ce_n(ce_n),
        .rd_n(rd_n), .wr_n(wr_n), .irq_ack_n(irq_ack_n), .dc_sel(dc_sel),
        .ab_sel(ab_sel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .chain_in(chain_in), .chain_out(chain_out), .int_req_n(int_req_n),
        .acc(acc), .acc_rdata(acc_rdata), .irq_src(irq_src), .evt_irq(evt_irq));
    shp_host_model i_shp_host_model (.sys_clk(sys_clk), .ce_n(ce_n), .rd_n(rd_n),
        .wr_n(wr_n), .irq_ack_n(irq_ack_n), .dc_sel(dc_sel), .ab_sel(ab_sel),
        .data_in(data_in), .chain_in(chain_in), .data_out(data_out));
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Channel stand-in answers with its index; counts writes
    always @(posedge sys_clk) begin
        acc_rdata <= {acc.ab_sel, 3'h5, acc.idx};
        if (acc.wr) begin
            n_wr <= n_wr + 1;
            last_acc <= acc;
        end
    end
    // ==========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Index a control access reaches after pointer byte p
    function automatic logic [3:0] ptr_idx(input logic [7:0] p);
        return {p[5:3] == CMD_POINT_HIGH, p[2:0]};
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t saw %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic dc, input logic [7:0] b);
        i_shp_host_model.xfer(1'h1, dc, ab, b, 4, 4, q);
    endtask
    task automatic rd(input logic dc);
        i_shp_host_model.xfer(1'h0, dc, ab, 8'h00, 4, 4, q);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog well beyond the roughly 440 cycles needed
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        report_and_stop();
    end
    // ==========
    // Main sequence
    initial begin
        {rstn, ab, irq_src} = '0;
        rs = 32'hA;
        {err_total, n_tests} = '0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'h1;
        // Data select: random bytes, both channels
        repeat (4) begin
            rs = xs(rs);
            ab = rs[8];
            n0 = n_wr;
            wr(1'h1, rs[7:0]);
            chk(8'(n_wr - n0), 8'h01);
            chk(last_acc.wdata, rs[7:0]);
            chk({last_acc.ab_sel, last_acc.idx}, {ab, IDX_DATA});
            rd(1'h1);
            chk(q, {ab, 3'h5, IDX_DATA});
        end
        // Pointer loads; data access keeps, control access clears
        foreach (pv[i]) begin
            rs = xs(rs);
            n0 = n_wr;
            wr(1'h0, pv[i]);
            wr(1'h1, rs[7:0]);
            wr(1'h0, rs[15:8]);
            chk({last_acc.ab_sel, last_acc.idx}, {ab, ptr_idx(pv[i])});
            wr(1'h0, 8'h00);
            chk(8'(n_wr - n0), 8'h02);
        end
        $display("data and pointer tests done");
        // Second strobe inside recovery is dropped and flagged
        n0 = n_wr;
        i_shp_host_model.xfer(1'h1, 1'h1, ab, 8'h3C, 2, 0, q);
        i_shp_host_model.xfer(1'h1, 1'h1, ab, 8'hC3, 2, 4, q);
        chk(8'(n_wr - n0), 8'h01);
        wr(1'h0, {4'h0, IDX_EVT_MASK});
        wr(1'h0, 8'h08);
        chk(evt_irq, 1'h1);
        wr(1'h0, {4'h0, IDX_EVT_STAT});
        wr(1'h0, 8'h0F);
        // Access event is set again but masked
        chk(evt_irq, 1'h0);
        // Pin reset; an access in the stretch is dropped
        n0 = n_wr;
        i_shp_host_model.hw_reset();
        wr(1'h1, 8'h5A);
        chk(8'(n_wr - n0), 8'h00);
        wr(1'h0, {4'h0, IDX_EVT_STAT});
        rd(1'h0);
        chk(q & 8'h0C, 8'h0C);
        $display("recovery and reset tests done");
        // Vector, then a request held off while pointing at pending
        rs = xs(rs);
        v = rs[7:0];
        wr(1'h0, {4'h0, IDX_VECTOR});
        wr(1'h0, v);
        wr(1'h0, {4'h0, IDX_PENDING});
        @(posedge sys_clk);
        irq_src <= NSRC'(1) << (rs[15:8] % NSRC);
        repeat (12) @(posedge sys_clk);
        #1 chk(int_req_n, 1'h1);
        rd(1'h0);
        chk(q, 8'h00);
        repeat (8) @(posedge sys_clk);
        #1 chk(int_req_n, 1'h0);
        // Acknowledge: writes ignored, vector out, request dropped
        i_shp_host_model.set_ack(1'h0);
        n0 = n_wr;
        wr(1'h1, 8'h77);
        chk(8'(n_wr - n0), 8'h00);
        i_shp_host_model.ack_rd(q);
        chk(q, v);
        chk(int_req_n, 1'h1);
        i_shp_host_model.set_ack(1'h1);
        wr(1'h0, {2'h0, CMD_SVC_CLR, 3'h0});
        chk(int_req_n, 1'h0);
        @(posedge sys_clk);
        irq_src <= '0;
        $display("interrupt tests done");
        report_and_stop();
    end
endmodule

// file: shp_irq_unit.sv
// Pending bits, in-service latches, priority and daisy chain
`timescale 1ns/100ps
module shp_irq_unit
    import shp_pkg::*;
(
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic            soft_rst,
    // Source requests and pending update enable
    input  wire logic [NSRC-1:0] src,
    input  wire logic            upd_en,
    // Acknowledge control
    input  wire logic            ack_active,
    input  wire logic            ack_take,
    input  wire logic            svc_clr,
    input  wire logic            chain_in,
    // State and outputs
    output logic      [NSRC-1:0] pending_q,
    output logic      [NSRC-1:0] svc_q,
    output logic                 hit,
    output logic                 chain_out_q,
    output logic                 int_n_q
);

    logic [NSRC-1:0] elig;   // Pending above every in-service level

    // Highest set bit as a one-hot, bit NSRC-1 ranks first
    function automatic logic [NSRC-1:0] hi_onehot(input logic [NSRC-1:0] v);
        logic [NSRC-1:0] r;
        r = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // Bits at or below the highest in-service level are blocked
    function automatic logic [NSRC-1:0] blocked(input logic [NSRC-1:0] v);
        logic [NSRC-1:0] r;
        logic            seen;
        r = '0;
        seen = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            seen = seen | v[i];
            r[i] = seen;
        end
        return r;
    endfunction

    assign elig = pending_q & ~blocked(svc_q);
    assign hit  = chain_in & (|elig);

    // ==========================================================
    // Pending bits follow the sources only on enabled cycles
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pending_q <= '0;
        end else if (soft_rst) begin
            pending_q <= '0;
        end else if (upd_en) begin
            pending_q <= src;
        end
    end

    // In-service latches; a new set is applied after the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            svc_q <= '0;
        end else if (soft_rst) begin
            svc_q <= '0;
        end else begin
            svc_q <= (svc_q & ~(svc_clr ? hi_onehot(svc_q) : '0))
                   | ((ack_take && hit) ? hi_onehot(elig) : '0);
        end
    end

    // Request and chain outputs, registered to stay glitch free
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chain_out_q <= 1'b1;
            int_n_q     <= 1'b1;
        end else begin
            chain_out_q <= chain_in & ~(|svc_q) & ~(ack_active & (|elig));
            int_n_q     <= ~(|elig);
        end
    end

endmodule

// file: shp_pkg.sv
// Constants and carrier types for the serial controller host bus port
package shp_pkg;

    // ==========================================================
    // Synchroniser and timing counts, in sys_clk cycles
    localparam int         SYNC_STAGES     = 2;
    localparam logic [2:0] RECOVERY_CYC    = 3'h4;
    localparam logic [2:0] RST_STRETCH_CYC = 3'h4;

    // ==========================================================
    // Register indices seen through the pointer
    localparam logic [3:0] IDX_ZERO     = 4'h0;
    localparam logic [3:0] IDX_CMD      = 4'h0;
    localparam logic [3:0] IDX_VECTOR   = 4'h2;
    localparam logic [3:0] IDX_PENDING  = 4'h3;
    localparam logic [3:0] IDX_EVT_STAT = 4'h6;
    localparam logic [3:0] IDX_EVT_MASK = 4'h7;
    localparam logic [3:0] IDX_DATA     = 4'h8;

    // ==========================================================
    // Pointer command register fields and command codes
    localparam int         PTR_LSB        = 0;
    localparam int         PTR_MSB        = 2;
    localparam int         CMD_LSB        = 3;
    localparam int         CMD_MSB        = 5;
    localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
    localparam logic [2:0] CMD_SVC_CLR    = 3'h7;

    // ==========================================================
    // Interrupt sources, vector and event status layout
    localparam int         NSRC       = 6;
    localparam logic [7:0] VECTOR_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam int         EV_ACCESS  = 0;
    localparam int         EV_ACK     = 1;
    localparam int         EV_RESET   = 2;
    localparam int         EV_REFUSED = 3;
    localparam int         EV_W       = 4;

    // ==========================================================
    // Host pins as one bundle, all active levels as on the bus
    typedef struct packed {
        logic       ce_n;
        logic       rd_n;
        logic       wr_n;
        logic       irq_ack_n;
        logic       dc_sel;
        logic       ab_sel;
        logic       chain_in;
        logic [7:0] data;
    } shp_pins_t;

    // Access toward the channel registers
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ab_sel;
        logic [3:0] idx;
        logic [7:0] wdata;
    } shp_acc_t;

endpackage

// file: shp_sync.sv
// Two-flop synchroniser for the asynchronous host pins
`timescale 1ns/100ps
module shp_sync
    import shp_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;   // First stage, read only by second
    logic [W-1:0] sync_q;   // Second stage, safe to use

    // ==========================================================
    // Idle high so released strobes never look like a reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule
